/* File: dci_pkg.sv */
// Purpose: Shared constants and types for the dual processor interrupt router
// Assumes: One 40 MHz clock shared by both ends
// Notes:   Port numbers are full 8-bit I/O addresses
package dci_pkg;
  // ------------------------------------------------------------
  // I/O port map
  // ------------------------------------------------------------
  localparam logic [7:0] SLAVE_PORT  = 8'hf0; // Slave even port
  localparam logic [7:0] MASTER_PORT = 8'hf2; // Master even port
  // ------------------------------------------------------------
  // Control word fields
  // ------------------------------------------------------------
  localparam int INIT_BIT = 4; // Even write: init word
  localparam int EOI_BIT  = 5; // Even write: end of interrupt
  // ------------------------------------------------------------
  // Vectoring
  // ------------------------------------------------------------
  localparam logic [7:0] CALL_OPCODE   = 8'hcd; // 8-bit call
  localparam logic [2:0] DEFAULT_LEVEL = 3'h7;  // No request left
  localparam logic [2:0] CASCADE_LEVEL = 3'h3;  // Slave input
  localparam logic [2:0] SWAP_LEVEL    = 3'h1;  // Swap request
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_RESET = 8'hff; // All masked
  localparam logic [7:0] BASE_RESET = 8'h00;
  // ------------------------------------------------------------
  // State types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ACK_IDLE   = 3'b001,
    ACK_SECOND = 3'b010,
    ACK_THIRD  = 3'b100
  } dci_ack_state_t;
  typedef enum logic [3:0] {
    H_IDLE   = 4'b0001,
    H_SETUP  = 4'b0010,
    H_STROBE = 4'b0100,
    H_WAIT   = 4'b1000
  } dci_host_state_t;
endpackage

/* File: dci_if.sv */
// Purpose: Carrier between the host processor end and the router end
// Assumes: Both ends run on the same clock
// Notes:   The shared data bus is resolved here from the router enable
`timescale 1ns/1ps
interface dci_if;
  logic [7:0] io_addr;           // Port address, bit 0 picks register
  logic [7:0] data_h;            // Host data out
  logic       data_h_oe_n;       // Host drives bus when low
  logic [7:0] data_d;            // Router data out
  logic       data_d_oe_n;       // Router drives bus when low
  logic [7:0] data_bus;          // Resolved bus level
  logic       host_write_strobe; // One-cycle write pulse
  logic       host_read_strobe;  // One-cycle read pulse
  logic       inta;              // One-cycle acknowledge pulse
  logic       cpu16_active;      // High: 16-bit processor runs
  logic       int8_req;          // 8-bit processor interrupt
  logic       int16_req;         // 16-bit processor interrupt
  logic       trap8;             // 8-bit processor trap
  logic       nmi16;             // 16-bit processor nonmaskable
  logic       force_swap;        // Force the 16-bit processor on
  // Router wins while it drives; otherwise host level stands
  assign data_bus = !data_d_oe_n ? data_d : data_h;
  modport device (
    input  io_addr, data_bus, host_write_strobe, host_read_strobe,
    input  inta, cpu16_active,
    output data_d, data_d_oe_n, int8_req, int16_req, trap8, nmi16,
    output force_swap
  );
  modport host (
    input  data_bus, int8_req, int16_req, trap8, nmi16, force_swap,
    output io_addr, data_h, data_h_oe_n, host_write_strobe,
    output host_read_strobe, inta, cpu16_active
  );
endinterface

/* File: dci_router.sv */
// Purpose: Cascaded pair of 8-level priority controllers plus routing
// Assumes: Request, vectored and nonmaskable inputs are asynchronous pins
// Notes:   Index 0 is the master, index 1 the slave
//
// Behaviour
// - Master at f2/f3, slave at f0/f1
// - Host data settles before write strobe
// - Master ranks level 0 highest, 7 lowest
// - Slave interrupt output raises master level 3
// - Each level masked on its own
// - Pending request raises processor interrupt
// - Higher request preempts the one in service
// - 8-bit mode: first acknowledge returns call opcode
// - 8-bit host gives two more acknowledges
// - Second gives low byte, third high byte
// - Vectors programmed before interrupts enabled
// - 16-bit mode: first acknowledge leaves bus free
// - 16-bit mode: second gives level type number
// - 16-bit acknowledges with one idle cycle between
// - Cascaded level 3: slave supplies the vector
// - No request at first acknowledge means level 7
// - Nonmaskable path has no software block
// - Power fail held low until clear
// - Option includes or excludes power fail
// - Retimed request goes to active processor only
// - Nonmaskable to trap or 16-bit input
// - Pending with swap mask forces 16-bit
`timescale 1ns/1ps
module dci_router (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       parity_error_request,
  input  wire logic       processor_swap_request,
  input  wire logic       timer_request,
  input  wire logic       serial_a_request,
  input  wire logic       serial_b_request,
  input  wire logic       keyboard_request,
  input  wire logic       display_request,
  input  wire logic       printer_request,
  input  wire logic [7:0] s100_vi,
  input  wire logic       nmi_n,
  input  wire logic       power_fail_n,
  input  wire logic       power_fail_en,
  input  wire logic       swap_mask_bit,
  output logic            combined_int_pending,
  dci_if.device           bus
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] mreq_raw;       // Master pins, level 3 unused
  logic [7:0] mreq_s1_reg;    // First stage
  logic [7:0] mreq_s2_reg;    // Second stage
  logic [7:0] vi_s1_reg;
  logic [7:0] vi_s2_reg;
  logic [1:0] nmi_s1_reg;     // {power fail, nmi}, active low
  logic [1:0] nmi_s2_reg;

  assign mreq_raw = {printer_request, keyboard_request | display_request,
                     serial_b_request, serial_a_request, 1'b0,
                     timer_request, processor_swap_request,
                     parity_error_request};

  // Two flops per pin; first stage read by second only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mreq_s1_reg <= 8'h00;
      mreq_s2_reg <= 8'h00;
      vi_s1_reg   <= 8'h00;
      vi_s2_reg   <= 8'h00;
      nmi_s1_reg  <= 2'h3;
      nmi_s2_reg  <= 2'h3;
    end else if (ce) begin
      mreq_s1_reg <= mreq_raw;
      mreq_s2_reg <= mreq_s1_reg;
      vi_s1_reg   <= s100_vi;
      vi_s2_reg   <= vi_s1_reg;
      nmi_s1_reg  <= {power_fail_n, nmi_n};
      nmi_s2_reg  <= nmi_s1_reg;
    end
  end

  // ------------------------------------------------------------
  // Priority helper: lowest index wins
  // ------------------------------------------------------------
  function automatic logic [3:0] pick(input logic [7:0] v);
    logic [3:0] r;
    r = {1'b0, dci_pkg::DEFAULT_LEVEL};
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Controller pair
  // ------------------------------------------------------------
  logic [7:0] req     [2];     // Request lines per controller
  logic [7:0] mask_reg[2];     // Mask, bit set blocks level
  logic [7:0] lo_reg  [2];     // Low vector / init word
  logic [7:0] hi_reg  [2];     // High vector / type base
  logic [7:0] isr_reg [2];     // In service
  logic [7:0] pend    [2];     // Unmasked requests
  logic [3:0] top_p   [2];     // {valid, level} pending
  logic [3:0] top_s   [2];     // {valid, level} in service
  logic [1:0] int_out;         // Controller interrupt outputs
  logic [1:0] set_isr;         // Acknowledge hits controller
  logic [2:0] set_lvl [2];     // Level to mark in service

  assign req[0] = {mreq_s2_reg[7:4], int_out[1], mreq_s2_reg[2:0]};
  assign req[1] = vi_s2_reg;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pic
      logic       hit;         // This controller's two ports
      logic       hi_next_reg; // Next odd write is high byte
      logic [7:0] eoi_clr;     // Bit cleared by end of interrupt
      assign hit = bus.io_addr[7:1] ==
                   (g == 0 ? dci_pkg::MASTER_PORT[7:1]
                           : dci_pkg::SLAVE_PORT[7:1]);
      assign pend[g]  = req[g] & ~mask_reg[g];
      assign top_p[g] = pick(pend[g]);
      assign top_s[g] = pick(isr_reg[g]);
      // Raise on a pending request when none is in service, or one above the level in service
      assign int_out[g] = top_p[g][3] &&
                          (!top_s[g][3] || top_p[g][2:0] < top_s[g][2:0]);
      assign eoi_clr = top_s[g][3] ? 8'(1) << top_s[g][2:0] : 8'h00;

      // Register writes; bus.io_addr[0] is buffered_addr_bit0
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          mask_reg[g] <= dci_pkg::MASK_RESET;
          lo_reg[g]   <= dci_pkg::BASE_RESET;
          hi_reg[g]   <= dci_pkg::BASE_RESET;
          hi_next_reg <= 1'b0;
        end else if (ce && hit && bus.host_write_strobe) begin
          if (!bus.io_addr[0]) begin
            if (bus.data_bus[dci_pkg::INIT_BIT]) begin
              // Init word: mask all until software opens levels
              lo_reg[g]   <= bus.data_bus;
              mask_reg[g] <= dci_pkg::MASK_RESET;
              hi_next_reg <= 1'b1;
            end
          end else if (hi_next_reg) begin
            hi_reg[g]   <= bus.data_bus;
            hi_next_reg <= 1'b0;
          end else begin
            mask_reg[g] <= bus.data_bus;
          end
        end
      end

      // In service: acknowledge sets, end of interrupt clears
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          isr_reg[g] <= 8'h00;
        end else if (ce) begin
          if (set_isr[g]) begin
            isr_reg[g] <= isr_reg[g] | (8'(1) << set_lvl[g]);
          end else if (hit && bus.host_write_strobe && !bus.io_addr[0]
                       && !bus.data_bus[dci_pkg::INIT_BIT]
                       && bus.data_bus[dci_pkg::EOI_BIT]) begin
            isr_reg[g] <= isr_reg[g] & ~eoi_clr;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Acknowledge sequencer
  // ------------------------------------------------------------
  dci_pkg::dci_ack_state_t ack_reg;  // Position in sequence
  logic [2:0] lvl_reg;               // Level being vectored
  logic [2:0] cas_reg;               // Cascade select lines
  logic       first;                 // First acknowledge now
  logic [2:0] m_lvl;                 // Master level at first
  logic [2:0] s_lvl;                 // Slave level at first
  logic       slv_sel;               // Slave owns the vector
  logic       slv_now;

  assign first   = bus.inta && ack_reg == dci_pkg::ACK_IDLE;
  assign m_lvl   = top_p[0][2:0];    // Level 7 when none left
  assign s_lvl   = top_p[1][2:0];
  assign slv_now = top_p[0][3] && m_lvl == dci_pkg::CASCADE_LEVEL;
  assign slv_sel = cas_reg == dci_pkg::CASCADE_LEVEL;
  assign set_isr = {ce && first && slv_now && top_p[1][3],
                    ce && first && top_p[0][3]};
  assign set_lvl[0] = m_lvl;
  assign set_lvl[1] = s_lvl;

  // Sequence state, level and cascade lines
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= dci_pkg::ACK_IDLE;
      lvl_reg <= dci_pkg::DEFAULT_LEVEL;
      cas_reg <= dci_pkg::DEFAULT_LEVEL;
    end else if (ce && bus.inta) begin
      case (ack_reg)
        dci_pkg::ACK_IDLE: begin
          cas_reg <= m_lvl;
          lvl_reg <= slv_now ? s_lvl : m_lvl;
          ack_reg <= dci_pkg::ACK_SECOND;
        end
        dci_pkg::ACK_SECOND: begin
          // 16-bit mode ends here; 8-bit needs one more
          ack_reg <= bus.cpu16_active ? dci_pkg::ACK_IDLE
                                      : dci_pkg::ACK_THIRD;
        end
        dci_pkg::ACK_THIRD: begin
          ack_reg <= dci_pkg::ACK_IDLE;
        end
        default: begin
          ack_reg <= dci_pkg::ACK_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Data bus answers: one cycle after each strobe
  // ------------------------------------------------------------
  logic [7:0] lo_vec;   // 8-bit low vector byte, interval 4
  logic [7:0] typ_vec;  // 16-bit type number
  logic [7:0] hi_vec;
  logic       rd_m;     // Read of master ports
  logic       rd_s;
  logic [1:0] rsel;
  assign lo_vec  = {lo_reg[slv_sel][7:5], lvl_reg, 2'b00};
  assign typ_vec = {hi_reg[slv_sel][7:3], lvl_reg};
  assign hi_vec  = hi_reg[slv_sel];
  assign rd_m = bus.host_read_strobe &&
                bus.io_addr[7:1] == dci_pkg::MASTER_PORT[7:1];
  assign rd_s = bus.host_read_strobe &&
                bus.io_addr[7:1] == dci_pkg::SLAVE_PORT[7:1];
  assign rsel = {rd_s, bus.io_addr[0]};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.data_d      <= 8'h00;
      bus.data_d_oe_n <= 1'b1;
    end else if (ce) begin
      bus.data_d_oe_n <= 1'b1;
      if (rd_m || rd_s) begin
        // Even port reads unmasked requests, odd reads mask
        bus.data_d_oe_n <= 1'b0;
        bus.data_d <= rsel[0] ? mask_reg[rsel[1]] : pend[rsel[1]];
      end else if (bus.inta) begin
        case (ack_reg)
          dci_pkg::ACK_IDLE: begin
            bus.data_d_oe_n <= bus.cpu16_active;
            bus.data_d      <= dci_pkg::CALL_OPCODE;
          end
          dci_pkg::ACK_SECOND: begin
            bus.data_d_oe_n <= 1'b0;
            bus.data_d <= bus.cpu16_active ? typ_vec : lo_vec;
          end
          dci_pkg::ACK_THIRD: begin
            bus.data_d_oe_n <= 1'b0;
            bus.data_d      <= hi_vec;
          end
          default: begin
            bus.data_d_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Routing: retime, steer, nonmaskable, swap force
  // ------------------------------------------------------------
  logic int_rt1_reg;  // Retime stage 1
  logic int_rt2_reg;  // Retime stage 2
  logic nmi_src;      // No mask term here on purpose
  assign nmi_src = !nmi_s2_reg[0] ||
                   (power_fail_en && !nmi_s2_reg[1]);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_rt1_reg          <= 1'b0;
      int_rt2_reg          <= 1'b0;
      bus.int8_req         <= 1'b0;
      bus.int16_req        <= 1'b0;
      bus.trap8            <= 1'b0;
      bus.nmi16            <= 1'b0;
      bus.force_swap       <= 1'b0;
      combined_int_pending <= 1'b0;
    end else if (ce) begin
      int_rt1_reg   <= int_out[0];
      int_rt2_reg   <= int_rt1_reg;
      // Select is trusted stable between instructions
      bus.int8_req  <= int_rt2_reg && !bus.cpu16_active;
      bus.int16_req <= int_rt2_reg && bus.cpu16_active;
      bus.trap8     <= nmi_src && !bus.cpu16_active;
      bus.nmi16     <= nmi_src && bus.cpu16_active;
      combined_int_pending <= int_rt2_reg || nmi_src;
      bus.force_swap <= (int_rt2_reg || nmi_src) && swap_mask_bit;
    end
  end
endmodule

/* File: dci_host.sv */
// Purpose: Host processor end: port cycles, acknowledges, swap select
// Assumes: Router answers one cycle after each strobe
// Notes:   Acknowledge beats a pending command when both wait
`timescale 1ns/1ps
module dci_host (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  input  wire logic        int_enable,
  input  wire logic        select_16,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             vec_valid,
  output logic [15:0]      vec_data,
  output logic             nmi_event,
  dci_if.host              bus
);
  // ------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------
  dci_pkg::dci_host_state_t st_reg;
  logic       ack_reg;   // Current cycle is an acknowledge
  logic [1:0] left_reg;  // Acknowledges still to issue
  logic [1:0] idx_reg;   // Acknowledge number, 0 first
  logic       int_line;  // Request of the active processor
  logic       take_ack;
  assign int_line = bus.cpu16_active ? bus.int16_req : bus.int8_req;
  assign take_ack = int_enable && int_line && !vec_valid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg    <= dci_pkg::H_IDLE;
      ack_reg   <= 1'b0;
      left_reg  <= 2'd0;
      idx_reg   <= 2'd0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      vec_valid <= 1'b0;
      vec_data  <= 16'h0000;
      bus.io_addr           <= 8'h00;
      bus.data_h            <= 8'h00;
      bus.data_h_oe_n       <= 1'b1;
      bus.host_write_strobe <= 1'b0;
      bus.host_read_strobe  <= 1'b0;
      bus.inta              <= 1'b0;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      vec_valid <= 1'b0;
      bus.host_write_strobe <= 1'b0;
      bus.host_read_strobe  <= 1'b0;
      bus.inta              <= 1'b0;
      case (st_reg)
        dci_pkg::H_IDLE: begin
          if (take_ack) begin
            ack_reg   <= 1'b1;
            idx_reg   <= 2'd0;
            left_reg  <= 2'd0;
            cmd_ready <= 1'b0;
            bus.inta  <= 1'b1;
            // Router answers a cycle after the pulse, so wait one out
            st_reg    <= dci_pkg::H_STROBE;
          end else if (cmd_valid && cmd_ready) begin
            // Address and data go out a cycle ahead of the strobe
            ack_reg         <= 1'b0;
            cmd_ready       <= 1'b0;
            bus.io_addr     <= cmd_addr;
            bus.data_h      <= cmd_wdata;
            bus.data_h_oe_n <= !cmd_write;
            bus.host_read_strobe <= 1'b0;
            left_reg <= {1'b0, cmd_write};
            st_reg   <= dci_pkg::H_SETUP;
          end
        end
        dci_pkg::H_SETUP: begin
          bus.host_write_strobe <= left_reg[0];
          bus.host_read_strobe  <= !left_reg[0];
          st_reg <= dci_pkg::H_STROBE;
        end
        dci_pkg::H_STROBE: begin
          st_reg <= dci_pkg::H_WAIT;
        end
        dci_pkg::H_WAIT: begin
          if (!ack_reg) begin
            bus.data_h_oe_n <= 1'b1;
            rsp_valid <= !left_reg[0];
            rsp_data  <= bus.data_bus;
            cmd_ready <= 1'b1;
            st_reg    <= dci_pkg::H_IDLE;
          end else begin
            // Each further pulse also needs its answer cycle; exits below win
            st_reg  <= dci_pkg::H_STROBE;
            idx_reg <= idx_reg + 2'd1;
            if (idx_reg == 2'd0) begin
              // 16-bit gives one more; 8-bit two after the call
              left_reg <= bus.cpu16_active ? 2'd1
                        : (bus.data_bus == dci_pkg::CALL_OPCODE ? 2'd2 : 2'd0);
              bus.inta <= bus.cpu16_active ||
                          bus.data_bus == dci_pkg::CALL_OPCODE;
            end else begin
              if (idx_reg == 2'd1) begin
                vec_data[7:0] <= bus.data_bus;
              end else begin
                vec_data[15:8] <= bus.data_bus;
              end
              left_reg <= left_reg - 2'd1;
              bus.inta <= left_reg == 2'd2;
            end
            if (idx_reg != 2'd0 && left_reg == 2'd1) begin
              vec_valid <= 1'b1;
              cmd_ready <= 1'b1;
              st_reg    <= dci_pkg::H_IDLE;
            end else if (idx_reg == 2'd0 && !bus.cpu16_active
                         && bus.data_bus != dci_pkg::CALL_OPCODE) begin
              cmd_ready <= 1'b1;
              st_reg    <= dci_pkg::H_IDLE;
            end
          end
        end
        default: begin
          st_reg <= dci_pkg::H_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Processor select and nonmaskable edge
  // ------------------------------------------------------------
  logic nmi_last_reg; // Previous nonmaskable level
  logic nmi_line;
  assign nmi_line = bus.cpu16_active ? bus.nmi16 : bus.trap8;

  // Select moves only while no cycle is open
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.cpu16_active <= 1'b0;
      nmi_last_reg     <= 1'b0;
      nmi_event        <= 1'b0;
    end else if (ce) begin
      if (st_reg == dci_pkg::H_IDLE && !take_ack) begin
        bus.cpu16_active <= select_16 || bus.force_swap;
      end
      nmi_last_reg <= nmi_line;
      nmi_event    <= nmi_line && !nmi_last_reg;
    end
  end
endmodule

/* File: dci_router_monitor.sv */
// Purpose: Checks on the link between host end and router end
// Assumes: One clock, asynchronous active low reset
// Notes:   Acknowledge position is tracked here from the pulses
`timescale 1ns/1ps
module dci_router_monitor (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] data_h,
  input wire logic       data_h_oe_n,
  input wire logic [7:0] data_d,
  input wire logic       data_d_oe_n,
  input wire logic       host_write_strobe,
  input wire logic       host_read_strobe,
  input wire logic       inta,
  input wire logic       cpu16_active,
  input wire logic       int8_req,
  input wire logic       int16_req,
  input wire logic       trap8,
  input wire logic       nmi16
);
  logic [1:0] ack_pos_reg; // Acknowledge index in the sequence
  logic       ack_last;    // Last acknowledge of the sequence
  logic       pic_port;    // Address hits f0..f3
  assign ack_last = ack_pos_reg == (cpu16_active ? 2'h1 : 2'h2);
  assign pic_port = io_addr[7:2] == 6'h3c;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Count acks; mode is steady inside a sequence, so wrap on it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ack_pos_reg <= 2'h0;
    else if (inta) ack_pos_reg <= ack_last ? 2'h0 : ack_pos_reg + 2'h1;
  end
  a_call_opcode: assert property (inta && ack_pos_reg == 2'h0 && !cpu16_active
    |=> !data_d_oe_n && data_d == dci_pkg::CALL_OPCODE) else $error("call opcode missing");
  a_first_free: assert property (inta && ack_pos_reg == 2'h0 && cpu16_active
    |=> data_d_oe_n) else $error("first ack drove bus");
  a_vector_drive: assert property (inta && ack_pos_reg != 2'h0 |=> !data_d_oe_n)
    else $error("vector byte not driven");
  a_drive_cause: assert property (!data_d_oe_n
    |-> $past(inta) || $past(host_read_strobe && pic_port)) else $error("stray bus drive");
  a_drive_short: assert property (!data_d_oe_n |=> data_d_oe_n)
    else $error("bus held too long");
  a_read_map: assert property (host_read_strobe && pic_port |=> !data_d_oe_n)
    else $error("mapped read not answered");
  a_write_setup: assert property (host_write_strobe
    |-> !data_h_oe_n && $past(!data_h_oe_n) && $stable(data_h)) else $error("write data late");
  a_inta_gap: assert property (inta |=> !inta) else $error("acks too close");
  a_int_steer: assert property (!(int8_req && int16_req)) else $error("int to both");
  a_nmi_steer: assert property (!(trap8 && nmi16)) else $error("nmi to both");
endmodule

/* File: test_dci_router.sv */
// Purpose: Self-checking bench for the router and host ends together
// Assumes: Inputs change 2 ns after the rising edge
// Notes:   Vector values follow the base bytes written at init
`timescale 1ns/1ps
module test_dci_router;
  logic        clk = 0, nrst = 0, cmd_valid = 0, cmd_write = 0, select_16 = 0;
  logic        swm = 0, nmi_n = 1, cmd_ready, rsp_valid, vec_valid, nmi_event;
  logic        pfn = 1, pfe = 0;  // Power fail pin and its include option
  logic [7:0]  cmd_addr = 0, cmd_wdata = 0, req = 0, s100 = 0, rsp_data;
  logic [15:0] vec_data;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  dci_if bus ();
  dci_router u_dci_router (.clk, .nrst, .ce(1'b1), .parity_error_request(req[0]),
    .processor_swap_request(req[1]), .timer_request(req[2]), .serial_a_request(req[4]),
    .serial_b_request(req[5]), .keyboard_request(req[6]), .display_request(req[6]),
    .printer_request(req[7]), .s100_vi(s100), .nmi_n, .power_fail_n(pfn),
    .power_fail_en(pfe), .swap_mask_bit(swm), .combined_int_pending(), .bus(bus));
  dci_host u_dci_host (.clk, .nrst, .ce(1'b1), .cmd_valid, .cmd_write, .cmd_addr,
    .cmd_wdata, .int_enable(1'b1), .select_16, .cmd_ready, .rsp_valid, .rsp_data,
    .vec_valid, .vec_data, .nmi_event, .bus(bus));
  dci_router_monitor u_mon (.clk, .nrst, .io_addr(bus.io_addr), .data_h(bus.data_h),
    .data_h_oe_n(bus.data_h_oe_n), .data_d(bus.data_d), .data_d_oe_n(bus.data_d_oe_n),
    .host_write_strobe(bus.host_write_strobe), .host_read_strobe(bus.host_read_strobe),
    .inta(bus.inta), .cpu16_active(bus.cpu16_active), .int8_req(bus.int8_req),
    .int16_req(bus.int16_req), .trap8(bus.trap8), .nmi16(bus.nmi16));
  always #12.5 clk = ~clk;
  task automatic test_done;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard: all tests fit well inside this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // One port cycle: hold the command until ready drops, then wait it out
  task automatic io(input logic w, input logic [7:0] a, d, output logic [7:0] r);
    int i;
    {cmd_write, cmd_addr, cmd_wdata, cmd_valid, r, i} = {w, a, d, 1'b1, 8'h00, 32'd0};
    do begin @(posedge clk); #2; i++; end while (cmd_ready === 1'b1 && i < 50);
    cmd_valid = 0;
    repeat (8) begin
      if (rsp_valid === 1'b1) r = rsp_data;
      if (cmd_ready === 1'b1) break;
      @(posedge clk); #2;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] r;
    io(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] r;
    io(1'b0, a, 8'h00, r);
    chk("port read", {8'h00, r}, {8'h00, e});
  endtask
  // Wait for a finished acknowledge sequence; a stale value fails the compare
  task automatic vec(input logic [15:0] e, m);
    repeat (300) begin @(posedge clk); #2; if (vec_valid === 1'b1) break; end
    chk("vector", vec_data & m, e);
  endtask
  task automatic idle;
    repeat (8) @(posedge clk);
    #2;
  endtask
  initial begin
    logic ev;
    repeat (8) @(posedge clk);
    #2 nrst = 1;
    wr(8'hf2, 8'h50); wr(8'hf3, 8'h12); wr(8'hf3, 8'hfb);
    rd(8'hf3, 8'hfb);
    rd(8'hf1, 8'hff);
    req[2] = 1;
    vec(16'h1248, 16'hffff);
    req[2] = 0; idle; wr(8'hf2, 8'h20);
    $display("test 8-bit vector done");
    select_16 = 1; wr(8'hf2, 8'h10); wr(8'hf3, 8'h80); wr(8'hf3, 8'hee);
    req[4] = 1;
    vec(16'h0084, 16'h00ff);
    req[0] = 1;
    vec(16'h0080, 16'h00ff);
    req = 0; idle; wr(8'hf2, 8'h20); wr(8'hf2, 8'h20);
    $display("test 16-bit priority done");
    wr(8'hf0, 8'h10); wr(8'hf1, 8'h90); wr(8'hf1, 8'hfe); wr(8'hf3, 8'he7);
    s100[0] = 1;
    vec(16'h0090, 16'h00ff);
    s100 = 0; idle; wr(8'hf0, 8'h20); wr(8'hf2, 8'h20);
    $display("test cascade done");
    {select_16, pfn} = 2'b00;
    idle; idle;
    chk("pf excluded", 16'(bus.trap8), 16'h0000);
    pfe = 1;
    idle;
    chk("pf trap", 16'(bus.trap8), 16'h0001);
    {pfe, pfn} = 2'b01;
    idle;
    $display("test power fail done");
    {select_16, swm, nmi_n, ev} = 4'b0100;
    repeat (30) begin @(posedge clk); #2; ev = ev | nmi_event; end
    chk("nmi event", 16'(ev), 16'h0001);
    chk("force swap", 16'(bus.force_swap), 16'h0001);
    $display("test nmi swap done");
    test_done;
  end
endmodule
